// File: rtl/hbi_fifo.sv
// Purpose: valid/ready FIFO of flip-flops
// Assumes: single clock
// Notes: WIDTH and DEPTH shape storage
`timescale 1ns/1ps
`default_nettype none
module hbi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } hbi_fifo_st_t;
    hbi_fifo_st_t s_reg, s_next;
    logic push, pop;
    assign in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_reg.cnt != '0;
    assign out_data  = s_reg.mem[s_reg.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data;
            s_next.wr = (s_reg.wr == AW'(DEPTH-1)) ? '0 : s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd = (s_reg.rd == AW'(DEPTH-1)) ? '0 : s_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule
`default_nettype wire

// File: rtl/hbi_host_if.sv
// Purpose: host I/O port, DMA handshake and interrupt routing
// Assumes: host pins synchronous to clk; config held by outside logic
// Notes: DMA write data from the host is buffered through a 16 word FIFO
`timescale 1ns/1ps
`default_nettype none
`include "hbi_params.svh"
// What this block does
// RULE1 - Drive data bus only during reads
// RULE2 - Read strobe low means read command
// RULE3 - Write strobe low means write command
// RULE4 - AEN high blocks all address decodes
// RULE5 - Latch address at strobe falling edge
// RULE6 - Decode compares all eleven address bits
// RULE7 - Raise DMA request per byte
// RULE8 - Last byte: acknowledge fall clears request
// RULE9 - Demand mode: read fall clears request
// RULE10 - DMA access only while acknowledge low
// RULE11 - Terminal count needs acknowledge; ends transfer
// RULE12 - Terminal count polarity follows host mode
// RULE13 - Route each interrupt to selected line
// RULE14 - Printer modes pulse interrupt low, release
// RULE15 - Respond only while chip select low
// RULE16 - Ready low stretches cycle when waiting
// RULE17 - Reset spares configuration inputs
// RULE18 - Unassigned DMA channels stay idle
module hbi_host_if
    import hbi_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire hbi_pkg::hbi_addr_t           host_io_address,
    input  wire hbi_pkg::hbi_data_t           host_data_in,
    output hbi_pkg::hbi_data_t                host_data_out,
    output logic                              host_data_oe,
    input  wire logic                         host_read_strobe_n,
    input  wire logic                         host_write_strobe_n,
    input  wire logic                         aen,
    input  wire logic                         upper_decode_select_n,
    output logic                              io_chan_ready_out,
    output logic                              io_chan_ready_oe,
    output logic                              dma_request_first,
    output logic                              dma_request_second,
    output logic                              dma_request_third,
    input  wire logic                         dma_ack_first_n,
    input  wire logic                         dma_ack_second_n,
    input  wire logic                         dma_ack_third_n,
    input  wire logic                         terminal_count,
    input  wire hbi_pkg::hbi_mode_t           host_mode,
    input  wire hbi_pkg::hbi_addr_t           func_base,
    input  wire logic                         func_wait,
    input  wire hbi_pkg::hbi_data_t           func_rd_data,
    output hbi_pkg::hbi_addr_t                func_addr,
    output logic                              func_rd_pulse,
    output logic                              func_wr_pulse,
    output hbi_pkg::hbi_data_t                func_wr_data,
    input  wire logic                         dma_enable,
    input  wire hbi_pkg::hbi_chsel_t          dma_channel_sel,
    input  wire logic                         dma_byte_want,
    input  wire logic                         dma_last_byte,
    input  wire logic                         dma_to_host,
    input  wire hbi_pkg::hbi_data_t           dma_src_data,
    output logic                              dma_done_pulse,
    output hbi_pkg::hbi_data_t                dma_sink_data,
    output logic                              dma_sink_valid,
    input  wire logic                         dma_sink_ready,
    input  wire logic [`HBI_NUM_FUNC-1:0]     func_irq,
    input  wire logic                         external_interrupt_input,
    input  wire hbi_pkg::hbi_irqsel_t         irq_route [`HBI_NUM_FUNC+1],
    input  wire logic                         enhanced_printer_mode,
    input  wire logic                         extended_printer_mode,
    output logic [`HBI_NUM_IRQ-1:0]           irq_out,
    output logic [`HBI_NUM_IRQ-1:0]           irq_oe
);
    import hbi_pkg::*;

    localparam int PULSE_CYC = `HBI_IRQ_PULSE_CYC;
    localparam int NSRC      = `HBI_NUM_FUNC + 1;

    typedef struct packed {
        logic                     rd_d;
        logic                     wr_d;
        logic                     rd_hit;
        hbi_addr_t                addr;
        hbi_data_t                dout;
        logic                     oe;
        logic                     frd;
        logic                     fwr;
        hbi_data_t                fwd;
        logic [`HBI_NUM_CH-1:0]   ack_d;
        logic                     drq;
        logic                     last;
        logic                     done;
        logic                     prn_src_d;
        logic [2:0]               pulse_cnt;
    } hbi_st_t;

    hbi_st_t s_reg, s_next;

    logic [`HBI_NUM_CH-1:0] ack_n_vec;
    logic                   ack_on, ack_fall, rd_fall, wr_fall, tc_seen;
    logic                   sel_ok, fifo_in_ready, fifo_push;
    logic                   prn_mode, prn_src, prn_rise;
    hbi_addr_t              cyc_addr;

    function automatic logic hit(input hbi_addr_t a, input hbi_addr_t base);
        return a == base;
    endfunction

    function automatic logic tc_active(input logic tc, input hbi_mode_t m);
        return (m == HBI_MODE_PS2) ? !tc : tc;
    endfunction

    assign ack_n_vec = {dma_ack_third_n, dma_ack_second_n, dma_ack_first_n};
    // RULE18 unassigned ack ignored
    assign ack_on    = dma_enable && (dma_channel_sel < 2'h3) && !ack_n_vec[dma_channel_sel];
    assign ack_fall  = ack_on && s_reg.ack_d[dma_channel_sel];
    // RULE2 read command
    assign rd_fall   = !host_read_strobe_n && s_reg.rd_d;
    // RULE3 write command
    assign wr_fall   = !host_write_strobe_n && s_reg.wr_d;
    // RULE15 chip select qualify
    // RULE4 aen blocks decode
    assign sel_ok    = !upper_decode_select_n && !aen;
    // RULE5 address at edge
    assign cyc_addr  = (rd_fall || wr_fall) ? host_io_address : s_reg.addr;
    // RULE11 tc needs ack
    // RULE12 tc polarity by mode
    assign tc_seen   = ack_on && tc_active(terminal_count, host_mode);
    assign fifo_push = ack_on && wr_fall && !dma_to_host;

    always_comb begin
        s_next        = s_reg;
        s_next.rd_d   = host_read_strobe_n;
        s_next.wr_d   = host_write_strobe_n;
        s_next.ack_d  = ack_n_vec;
        s_next.frd    = 1'b0;
        s_next.fwr    = 1'b0;
        s_next.done   = 1'b0;
        if (rd_fall || wr_fall) begin
            s_next.addr = host_io_address;
        end
        // RULE6 full address compare
        if (rd_fall && sel_ok && !ack_on && hit(host_io_address, func_base)) begin
            s_next.rd_hit = 1'b1;
            s_next.frd    = 1'b1;
        end
        if (host_read_strobe_n) begin
            s_next.rd_hit = 1'b0;
        end
        if (wr_fall && sel_ok && !ack_on && hit(host_io_address, func_base)) begin
            s_next.fwr = 1'b1;
            s_next.fwd = host_data_in;
        end
        // RULE10 dma read with ack
        if (rd_fall && ack_on && dma_to_host) begin
            s_next.rd_hit = 1'b1;
            s_next.dout   = dma_src_data;
        end else if (s_reg.frd) begin
            s_next.dout = func_rd_data;
        end
        // RULE1 drive only on read
        s_next.oe = s_next.rd_hit && !host_read_strobe_n;
        // RULE7 request per byte
        // May rise while acknowledge stays low (demand)
        if (dma_enable && dma_byte_want && !s_reg.drq) begin
            s_next.drq  = 1'b1;
            s_next.last = dma_last_byte;
        end
        if (s_reg.drq && s_reg.last) begin
            // RULE8 clear on ack fall
            if (ack_fall) begin
                s_next.drq = 1'b0;
            // RULE9 demand mode clear
            end else if (ack_on && rd_fall) begin
                s_next.drq = 1'b0;
            end
        end else if (s_reg.drq && ack_on && (rd_fall || wr_fall)) begin
            s_next.drq = 1'b0;
        end
        if (tc_seen && (rd_fall || wr_fall)) begin
            s_next.done = 1'b1;
            s_next.drq  = 1'b0;
        end
        if (!dma_enable) begin
            s_next.drq = 1'b0;
        end
        // RULE14 low pulse on event
        s_next.prn_src_d = prn_src;
        if (prn_rise) begin
            s_next.pulse_cnt = 3'(PULSE_CYC);
        end else if (s_reg.pulse_cnt != 3'h0) begin
            s_next.pulse_cnt = s_reg.pulse_cnt - 3'h1;
        end
    end

    // RULE17 config kept on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg      <= '0;
            s_reg.rd_d <= 1'b1;
            s_reg.wr_d <= 1'b1;
            s_reg.ack_d <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    hbi_fifo #(
        .WIDTH (`HBI_DATA_W),
        .DEPTH (`HBI_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (host_data_in),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (dma_sink_data),
        .out_valid (dma_sink_valid),
        .out_ready (dma_sink_ready)
    );

    assign host_data_out  = s_reg.dout;
    assign host_data_oe   = s_reg.oe;
    assign func_addr      = s_reg.addr;
    assign func_rd_pulse  = s_reg.frd;
    assign func_wr_pulse  = s_reg.fwr;
    assign func_wr_data   = s_reg.fwd;
    assign dma_done_pulse = s_reg.done;

    // RULE18 unassigned request idle
    assign dma_request_first  = s_reg.drq && (dma_channel_sel == 2'h0) && fifo_in_ready;
    assign dma_request_second = s_reg.drq && (dma_channel_sel == 2'h1) && fifo_in_ready;
    assign dma_request_third  = s_reg.drq && (dma_channel_sel == 2'h2) && fifo_in_ready;

    // RULE16 wait stretches cycle
    assign io_chan_ready_out = 1'b0;
    assign io_chan_ready_oe  = func_wait && s_reg.rd_hit | (func_wait && !host_write_strobe_n
                               && hit(cyc_addr, func_base) && sel_ok);

    assign prn_mode = enhanced_printer_mode || extended_printer_mode;
    assign prn_src  = func_irq[0];
    assign prn_rise = prn_mode && prn_src && !s_reg.prn_src_d;

    // RULE13 interrupt routing
    always_comb begin
        irq_out = '0;
        irq_oe  = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (irq_route[i] < 3'(`HBI_NUM_IRQ)) begin
                if (i == 0 && prn_mode) begin
                    if (s_reg.pulse_cnt != 3'h0) begin
                        irq_oe[irq_route[i]] = 1'b1;
                    end
                end else begin
                    irq_oe[irq_route[i]] = 1'b1;
                    if ((i < `HBI_NUM_FUNC) ? func_irq[i] : external_interrupt_input) begin
                        irq_out[irq_route[i]] = 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/hbi_params.svh
// Purpose: constants for the host bus interface
// Assumes: 10 MHz clock
// Notes: fields and timing counts
`ifndef HBI_PARAMS_SVH
`define HBI_PARAMS_SVH
`define HBI_ADDR_W        11
`define HBI_DATA_W        8
`define HBI_NUM_CH        3
`define HBI_NUM_IRQ       6
`define HBI_NUM_FUNC      4
`define HBI_FIFO_DEPTH    16
`define HBI_CLK_NS        100
`define HBI_IRQ_PULSE_NS  300
`define HBI_IRQ_PULSE_CYC ((`HBI_IRQ_PULSE_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS)
`define HBI_ROUTE_NONE    3'h7
`endif

// File: rtl/hbi_pkg.sv
// Purpose: types for the host bus interface
// Assumes: constants from hbi_params.svh
// Notes: modes and channel selectors
`include "hbi_params.svh"
package hbi_pkg;
    typedef enum logic [1:0] {HBI_MODE_AT, HBI_MODE_M30, HBI_MODE_PS2} hbi_mode_t;
    typedef logic [1:0] hbi_chsel_t;
    typedef logic [2:0] hbi_irqsel_t;
    typedef logic [`HBI_ADDR_W-1:0] hbi_addr_t;
    typedef logic [`HBI_DATA_W-1:0] hbi_data_t;
endpackage

// File: tb/hbi_host_if_properties.sv
// Purpose: port checks of the host bus interface
// Assumes: one clock, rst active high
// Notes: DMA checks watch the first channel
`timescale 1ns/1ps
`default_nettype none
module hbi_host_if_properties (
    input wire logic                clk,
    input wire logic                rst,
    input wire hbi_pkg::hbi_addr_t  host_io_address,
    input wire logic                host_data_oe,
    input wire logic                host_read_strobe_n,
    input wire logic                host_write_strobe_n,
    input wire logic                aen,
    input wire logic                upper_decode_select_n,
    input wire hbi_pkg::hbi_addr_t  func_base,
    input wire logic                func_rd_pulse,
    input wire logic                func_wr_pulse,
    input wire logic                dma_request_first,
    input wire logic                dma_ack_first_n,
    input wire logic                dma_enable,
    input wire hbi_pkg::hbi_chsel_t dma_channel_sel,
    input wire logic                dma_last_byte,
    input wire logic                terminal_count,
    input wire hbi_pkg::hbi_mode_t  host_mode,
    input wire logic                dma_done_pulse
);
    import hbi_pkg::*;
    logic hit;
    logic tc_acc;
    assign hit = !aen && !upper_decode_select_n && dma_ack_first_n && host_io_address == func_base;
    assign tc_acc = dma_enable && !dma_ack_first_n && dma_channel_sel == 2'h0
                    && (terminal_count ^ (host_mode == HBI_MODE_PS2));
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_rd_hit;
        $fell(host_read_strobe_n) && hit;
    endsequence
    sequence s_rd_answer;
        func_rd_pulse && host_data_oe ##1 host_data_oe;
    endsequence
    a_oe_read_only: assert property (host_data_oe |-> !$past(host_read_strobe_n) || !$past(host_read_strobe_n, 2))
        else $error("data bus driven outside a read");
    a_read_taken: assert property (s_rd_hit |=> s_rd_answer)
        else $error("decoded read not answered");
    a_write_taken: assert property ($fell(host_write_strobe_n) && hit |=> func_wr_pulse)
        else $error("decoded write not taken");
    a_decode_refused: assert property (($fell(host_read_strobe_n) || $fell(host_write_strobe_n)) && !hit
        && dma_ack_first_n |=> !func_rd_pulse && !func_wr_pulse)
        else $error("undecoded cycle taken");
    a_drq_ack_last: assert property (dma_channel_sel == 2'h0 && dma_request_first && dma_last_byte
        && $fell(dma_ack_first_n) |=> !dma_request_first)
        else $error("request kept after last acknowledge");
    a_drq_demand: assert property (dma_channel_sel == 2'h0 && dma_request_first && !$past(dma_ack_first_n)
        && !dma_ack_first_n && $fell(host_read_strobe_n) |=> !dma_request_first)
        else $error("request kept after demand read");
    a_drq_unassigned: assert property (dma_channel_sel == 2'h3 |-> !dma_request_first)
        else $error("request on unassigned channel");
    a_tc_accept: assert property (tc_acc && ($fell(host_read_strobe_n) || $fell(host_write_strobe_n))
        |=> dma_done_pulse)
        else $error("terminal count not accepted");
    a_tc_ignored: assert property (dma_ack_first_n && $past(dma_ack_first_n) |-> !dma_done_pulse)
        else $error("terminal count taken without acknowledge");
endmodule
bind hbi_host_if hbi_host_if_properties i_props (
    .clk, .rst, .host_io_address, .host_data_oe, .host_read_strobe_n, .host_write_strobe_n, .aen,
    .upper_decode_select_n, .func_base, .func_rd_pulse, .func_wr_pulse, .dma_request_first,
    .dma_ack_first_n, .dma_enable, .dma_channel_sel, .dma_last_byte, .terminal_count, .host_mode, .dma_done_pulse
);
`default_nettype wire

// File: tb/hbi_host_model.sv
// Purpose: host processor and DMA controller model
// Assumes: pins change after falling edges
// Notes: released lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module hbi_host_model (
    input  wire logic               clk,
    input  wire hbi_pkg::hbi_data_t host_data_out,
    input  wire logic               io_chan_ready_oe,
    output hbi_pkg::hbi_addr_t      host_io_address,
    output hbi_pkg::hbi_data_t      host_data_in,
    output logic                    host_read_strobe_n,
    output logic                    host_write_strobe_n,
    output logic                    aen,
    output logic                    dma_ack_first_n
);
    import hbi_pkg::*;
    initial begin
        host_io_address = 11'h7FF;
        host_data_in = 8'h00;
        host_read_strobe_n = 1'h1;
        host_write_strobe_n = 1'h1;
        aen = 1'h0;
        dma_ack_first_n = 1'h1;
    end
    task automatic io(input logic wr, input logic ae, input logic ak, input logic kp,
                      input hbi_addr_t a, input hbi_data_t d, output hbi_data_t q);
        @(negedge clk);
        host_io_address = a;
        host_data_in = wr ? d : ~host_data_in;
        aen = ae;
        dma_ack_first_n = !ak;
        @(negedge clk);
        host_read_strobe_n = wr;
        host_write_strobe_n = !wr;
        repeat (3) @(posedge clk);
        while (io_chan_ready_oe === 1'h1)
            @(posedge clk);
        @(negedge clk);
        q = host_data_out;
        host_read_strobe_n = 1'h1;
        host_write_strobe_n = 1'h1;
        host_io_address = ~a;
        host_data_in = ~host_data_in;
        aen = 1'h0;
        dma_ack_first_n = !kp;
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench of the host bus interface
// Assumes: host model drives the bus pins
// Notes: decode, wait, DMA with FIFO, interrupts
`timescale 1ns/1ps
`default_nettype none
`include "hbi_params.svh"
module tb;
    import hbi_pkg::*;
    logic clk = 1'h0, rst = 1'h1, upper_decode_select_n = 1'h0, func_wait = 1'h0, dma_enable = 1'h1;
    logic dma_byte_want = 1'h0, dma_last_byte = 1'h0, dma_to_host = 1'h0, dma_sink_ready = 1'h0;
    logic terminal_count = 1'h0, external_interrupt_input = 1'h0;
    logic enhanced_printer_mode = 1'h0, extended_printer_mode = 1'h0;
    logic [`HBI_NUM_FUNC-1:0] func_irq = '0;
    hbi_mode_t host_mode = HBI_MODE_AT;
    hbi_chsel_t dma_channel_sel = 2'h0;
    hbi_irqsel_t irq_route [`HBI_NUM_FUNC+1] = '{default: 3'h7};
    hbi_addr_t host_io_address, func_addr;
    hbi_data_t host_data_in, host_data_out, func_wr_data, dma_sink_data;
    logic host_data_oe, io_chan_ready_oe, host_read_strobe_n, host_write_strobe_n, aen, dma_ack_first_n;
    logic dma_request_first, dma_request_second, dma_request_third, func_rd_pulse, func_wr_pulse;
    logic dma_done_pulse, dma_sink_valid;
    logic [`HBI_NUM_IRQ-1:0] irq_out, irq_oe;
    int error_cnt = 0, checks_done = 0, rdc = 0, wrc = 0, donec = 0, waitc = 0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        rdc <= rdc + int'(func_rd_pulse === 1'h1);
        wrc <= wrc + int'(func_wr_pulse === 1'h1);
        donec <= donec + int'(dma_done_pulse === 1'h1);
        waitc <= waitc + int'(io_chan_ready_oe === 1'h1);
    end
    hbi_host_model i_hbi_host_model (.clk, .host_data_out, .io_chan_ready_oe, .host_io_address,
        .host_data_in, .host_read_strobe_n, .host_write_strobe_n, .aen, .dma_ack_first_n);
    hbi_host_if i_hbi_host_if (.clk, .rst, .host_io_address, .host_data_in, .host_data_out, .host_data_oe,
        .host_read_strobe_n, .host_write_strobe_n, .aen, .upper_decode_select_n, .io_chan_ready_out(),
        .io_chan_ready_oe, .dma_request_first, .dma_request_second, .dma_request_third, .dma_ack_first_n,
        .dma_ack_second_n(1'h1), .dma_ack_third_n(1'h1), .terminal_count, .host_mode, .func_base(11'h3F2),
        .func_wait, .func_rd_data(8'h3C), .func_addr, .func_rd_pulse, .func_wr_pulse, .func_wr_data,
        .dma_enable, .dma_channel_sel, .dma_byte_want, .dma_last_byte, .dma_to_host, .dma_src_data(8'h5A),
        .dma_done_pulse, .dma_sink_data, .dma_sink_valid, .dma_sink_ready, .func_irq,
        .external_interrupt_input, .irq_route, .enhanced_printer_mode, .extended_printer_mode, .irq_out, .irq_oe);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_io();
        hbi_data_t q;
        i_hbi_host_model.io(1'h1, 1'h0, 1'h0, 1'h0, 11'h3F2, 8'hA5, q);
        check(wrc, 1'h1);
        check(func_wr_data, 8'hA5);
        check(func_addr, 11'h3F2);
        i_hbi_host_model.io(1'h0, 1'h0, 1'h0, 1'h0, 11'h3F2, 8'h00, q);
        check(q, 8'h3C);
        for (int i = 0; i < 4; i++) begin
            upper_decode_select_n = (i == 1);
            i_hbi_host_model.io(i[0], i == 0, 1'h0, 1'h0, (i == 2) ? 11'h3F3 : (i == 3) ? 11'h7F2 : 11'h3F2, 8'h11, q);
        end
        upper_decode_select_n = 1'h0;
        check(rdc + wrc, 2'h2);
    endtask
    task automatic t_wait();
        hbi_data_t q;
        func_wait = 1'h1;
        fork
            i_hbi_host_model.io(1'h0, 1'h0, 1'h0, 1'h0, 11'h3F2, 8'h00, q);
            begin
                repeat (6) @(negedge clk);
                func_wait = 1'h0;
            end
        join
        check(waitc > 0, 1'h1);
        check(q, 8'h3C);
    endtask
    task automatic dma_byte(input logic wr, input logic kp, input hbi_data_t d, output hbi_data_t q);
        dma_byte_want = 1'h1;
        repeat (3) @(negedge clk);
        check(dma_request_first, 1'h1);
        dma_byte_want = 1'h0;
        i_hbi_host_model.io(wr, 1'h1, 1'h1, kp, 11'h000, d, q);
        check(dma_request_first, 1'h0);
    endtask
    task automatic t_dma();
        hbi_data_t q;
        for (int i = 0; i < 16; i++)
            dma_byte(1'h1, 1'h0, i[7:0], q);
        dma_byte_want = 1'h1;
        repeat (3) @(negedge clk);
        check(dma_request_first, 1'h0);
        dma_byte_want = 1'h0;
        dma_sink_ready = 1'h1;
        for (int i = 0; i < 17; i++) begin
            check(dma_sink_valid, i < 16);
            check(dma_sink_data, (i < 16) ? i : dma_sink_data);
            @(negedge clk);
        end
        // Serve the request left pending while the FIFO was full
        dma_byte(1'h1, 1'h0, 8'h77, q);
        dma_to_host = 1'h1;
        dma_last_byte = 1'h1;
        dma_byte(1'h0, 1'h0, 8'h00, q);
        check(q, 8'h5A);
        dma_last_byte = 1'h0;
        dma_byte(1'h0, 1'h1, 8'h00, q);
        dma_last_byte = 1'h1;
        dma_byte(1'h0, 1'h0, 8'h00, q);
        for (int m = 0; m < 3; m++) begin
            host_mode = hbi_mode_t'(m);
            terminal_count = (m != 2);
            repeat (3) @(negedge clk);
            check(donec, m);
            i_hbi_host_model.io(1'h0, 1'h1, 1'h1, 1'h0, 11'h000, 8'h00, q);
            check(donec, m + 1);
            terminal_count = (m == 1);
        end
        for (int c = 1; c < 4; c++) begin
            dma_channel_sel = c[1:0];
            dma_byte_want = 1'h1;
            repeat (3) @(negedge clk);
            check({dma_request_first, dma_request_second, dma_request_third}, 3'h4 >> c);
        end
        dma_byte_want = 1'h0;
    endtask
    task automatic t_irq();
        int n;
        irq_route[1] = 3'h4;
        irq_route[4] = 3'h0;
        func_irq[1] = 1'h1;
        external_interrupt_input = 1'h1;
        @(negedge clk);
        check({irq_out[4], irq_out[0], irq_out[2]}, 3'h6);
        irq_route[0] = 3'h2;
        for (int p = 0; p < 2; p++) begin
            enhanced_printer_mode = !p[0];
            extended_printer_mode = p[0];
            func_irq[0] = 1'h1;
            n = 0;
            repeat (6) begin
                @(negedge clk);
                n += int'(irq_oe[2] === 1'h1 && irq_out[2] === 1'h0);
            end
            check(n, `HBI_IRQ_PULSE_CYC);
            check(irq_oe[2], 1'h0);
            func_irq[0] = 1'h0;
            @(negedge clk);
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'h0;
        t_io();
        t_wait();
        t_dma();
        t_irq();
        finish_test();
    end
    initial begin
        #1000000;
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
